//--- se_dev.sv
// Serial memory slave: read path, address counter and busy poll answer
// Notes on behaviour
// - No address acknowledge while write busy
// - Master polls with start plus address word
// - Direction bit one means read
// - Counter holds last accessed address plus one
// - Counter survives between transactions until reset
// - Read increment wraps across whole array
// - Read sends counter byte, MSB first
// - Master ends single read with nack, stop
// - Random read: dummy write, restart, read
// - Dummy write acks, loads counter, no store
// - Sequential read continues on master ack
// - Each byte sent increments counter; master ack sends next byte
// - Sequential read wraps without interruption
// - Master ends sequential read with nack, stop
// - Address word 1010, strap bits, direction
// - Eight-bit words, ack low on ninth clock
// - Stop returns slave to standby
`timescale 1ns/10ps
`default_nettype none
`include "se_map.svh"

module se_dev #(
  parameter int DEPTH = `SE_MEM_BYTES
) (
  input wire logic clock,                          // User side clock
  input wire logic reset_n,                        // Async reset, active low
  input wire logic link_clk,                       // Link side clock
  input wire logic write_busy,                     // Self-timed write running
  input wire logic chip_strap_bit0,                // Address strap 0
  input wire logic chip_strap_bit1,                // Address strap 1
  input wire logic chip_strap_bit2,                // Address strap 2
  input wire logic fill_valid,                     // Preload request
  input wire logic [`SE_ADDR_W-1:0] fill_addr,     // Preload address
  input wire logic [7:0] fill_data,                // Preload byte
  output logic fill_ready,                         // Preload port free
  se_link_if.dev link                              // Two-wire link
);
  import se_pkg::*;

  // ==========================================================
  // Storage
  logic [7:0] mem [DEPTH];

  // ==========================================================
  // User side: preload request, toggle handshake
  logic fill_req;
  logic next_fill_req;
  logic [`SE_ADDR_W-1:0] hold_addr;
  logic [`SE_ADDR_W-1:0] next_hold_addr;
  logic [7:0] hold_data;
  logic [7:0] next_hold_data;
  logic next_fill_ready;
  logic ack_s1;
  logic ack_s2;
  logic fill_ack;

  always_comb begin
    next_fill_req = fill_req;
    next_hold_addr = hold_addr;
    next_hold_data = hold_data;
    if (fill_valid && fill_ready) begin
      next_fill_req = ~fill_req;
      next_hold_addr = fill_addr;
      next_hold_data = fill_data;
    end
    next_fill_ready = (next_fill_req == ack_s2);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fill_req <= 1'b0;
      hold_addr <= '0;
      hold_data <= 8'h00;
      fill_ready <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      fill_req <= next_fill_req;
      hold_addr <= next_hold_addr;
      hold_data <= next_hold_data;
      fill_ready <= next_fill_ready;
      ack_s1 <= fill_ack;
      ack_s2 <= ack_s1;
    end
  end

  // ==========================================================
  // Link side synchronisers
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic busy_s1, busy_s2;
  logic [2:0] strap_s1, strap_s2;
  logic req_s1, req_s2, req_d;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_d <= 1'b0;
    end else begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      busy_s1 <= write_busy;
      busy_s2 <= busy_s1;
      strap_s1 <= {chip_strap_bit2, chip_strap_bit1, chip_strap_bit0};
      strap_s2 <= strap_s1;
      req_s1 <= fill_req;
      req_s2 <= req_s1;
      req_d <= req_s2;
    end
  end

  // Hold registers stay still while a request is in flight
  always_ff @(posedge link_clk) begin
    if (req_s2 != req_d) begin
      mem[hold_addr] <= hold_data;
    end
  end

  // ==========================================================
  // Link side protocol engine
  logic scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  // Own drive changes only after SCL falls, so it never fakes these
  assign start_seen = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_seen = scl_s2 && scl_d && !sda_d && sda_s2;

  se_dstate_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [`SE_ADDR_W-1:0] addr, next_addr;
  logic rw, next_rw;
  logic ack_seen, next_ack_seen;
  logic oe, next_oe;
  logic next_fill_ack;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_addr = addr;
    next_rw = rw;
    next_ack_seen = ack_seen;
    next_oe = oe;
    next_fill_ack = (req_s2 != req_d) ? ~fill_ack : fill_ack;
    if (stop_seen) begin
      next_state = SE_D_IDLE;
      next_oe = 1'b0;
    end else if (start_seen) begin
      next_state = SE_D_DEVADR;
      next_cnt = 4'd0;
      next_oe = 1'b0;
    end else begin
      case (state)
        SE_D_DEVADR, SE_D_WADDR: begin
          if (scl_rise && cnt < `SE_ACK_BIT) begin
            next_sh = {sh[6:0], sda_s2};
            next_cnt = cnt + 4'd1;
          end else if (scl_fall && cnt == `SE_ACK_BIT) begin
            if (state == SE_D_WADDR) begin
              next_addr = sh;
              next_oe = 1'b1;
              next_state = SE_D_ACK_WA;
            end else if (sh[7:4] == `SE_DEV_TYPE && sh[3:1] == strap_s2
                         && !busy_s2) begin
              next_rw = (sh[0] == `SE_RW_READ);
              next_oe = 1'b1;
              next_state = SE_D_ACK_DEV;
            end else begin
              next_state = SE_D_IDLE;
            end
          end
        end
        SE_D_ACK_DEV: begin
          if (scl_fall) begin
            next_cnt = 4'd0;
            if (rw) begin
              next_sh = mem[addr];
              next_oe = ~mem[addr][7];
              next_state = SE_D_RDATA;
            end else begin
              next_oe = 1'b0;
              next_state = SE_D_WADDR;
            end
          end
        end
        SE_D_ACK_WA: begin
          // Data bytes of a write are not stored; wait for restart or stop
          if (scl_fall) begin
            next_oe = 1'b0;
            next_state = SE_D_HOLD;
          end
        end
        SE_D_RDATA: begin
          if (scl_fall) begin
            if (cnt == `SE_LAST_BIT) begin
              next_oe = 1'b0;
              next_addr = addr + 8'h01;
              next_state = SE_D_RACK;
            end else begin
              next_sh = {sh[6:0], 1'b0};
              next_oe = ~sh[6];
              next_cnt = cnt + 4'd1;
            end
          end
        end
        SE_D_RACK: begin
          if (scl_rise) begin
            next_ack_seen = ~sda_s2;
          end else if (scl_fall) begin
            if (ack_seen) begin
              next_cnt = 4'd0;
              next_sh = mem[addr];
              next_oe = ~mem[addr][7];
              next_state = SE_D_RDATA;
            end else begin
              next_state = SE_D_HOLD;
            end
          end
        end
        SE_D_IDLE, SE_D_HOLD: begin
          next_oe = 1'b0;
        end
        default: begin
          next_state = SE_D_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // Counter reset only by power-on reset, never by stop or start
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= SE_D_IDLE;
      cnt <= 4'd0;
      sh <= 8'h00;
      addr <= '0;
      rw <= 1'b0;
      ack_seen <= 1'b0;
      oe <= 1'b0;
      fill_ack <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      addr <= next_addr;
      rw <= next_rw;
      ack_seen <= next_ack_seen;
      oe <= next_oe;
      fill_ack <= next_fill_ack;
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = oe;

endmodule

`default_nettype wire

//--- se_host.sv
// Two-wire bus master: current, random and sequential reads, busy polling
`timescale 1ns/10ps
`default_nettype none
`include "se_map.svh"

module se_host #(
  parameter int QTR = `SE_QTR_CYC
) (
  input wire logic clock,                          // System clock
  input wire logic reset_n,                        // Async reset, active low
  input wire logic cmd_valid,                      // Command request
  input wire se_pkg::se_kind_e cmd_kind,           // Read kind or poll
  input wire logic [2:0] cmd_strap,                // Target strap bits
  input wire logic [`SE_ADDR_W-1:0] cmd_addr,      // Word address, random read
  input wire logic [7:0] cmd_len,                  // Bytes to read minus one
  output logic cmd_ready,                          // Ready for a command
  output logic rd_valid,                           // Byte received, pulse
  output logic [7:0] rd_data,                      // Received byte
  output logic done,                               // Command finished, pulse
  output logic nack,                               // Last command refused
  se_link_if.host link                             // Two-wire link
);
  import se_pkg::*;

  // ==========================================================
  // Synchroniser for the shared data line
  logic sda_s1, sda_s2;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  // ==========================================================
  // Quarter-bit sequencer; SCL is divided from clock
  se_hstate_e st, next_st;
  se_kind_e kind, next_kind;
  logic [15:0] qc, next_qc;
  logic [1:0] q, next_q;
  logic [1:0] step, next_step;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic [7:0] len, next_len;
  logic [2:0] strap, next_strap;
  logic [`SE_ADDR_W-1:0] waddr, next_waddr;
  logic ackbit, next_ackbit;
  logic scl, next_scl;
  logic oe, next_oe;
  logic next_rd_valid, next_done, next_nack;
  logic [7:0] next_rd_data;
  logic tick;
  logic [1:0] nq;
  logic [7:0] devw, devr;

  assign tick = (qc == 16'(QTR - 1));
  assign nq = q + 2'd1;
  assign devw = {`SE_DEV_TYPE, strap, ~`SE_RW_READ};
  assign devr = {`SE_DEV_TYPE, strap, `SE_RW_READ};

  always_comb begin
    next_st = st;
    next_kind = kind;
    next_qc = tick ? 16'h0000 : qc + 16'h0001;
    next_q = q;
    next_step = step;
    next_bitn = bitn;
    next_sh = sh;
    next_len = len;
    next_strap = strap;
    next_waddr = waddr;
    next_ackbit = ackbit;
    next_scl = scl;
    next_oe = oe;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_done = 1'b0;
    next_nack = nack;
    if (st == SE_H_IDLE) begin
      next_qc = 16'h0000;
      next_q = 2'd0;
      next_scl = 1'b1;
      next_oe = 1'b0;
      if (cmd_valid && cmd_ready) begin
        next_kind = cmd_kind;
        next_strap = cmd_strap;
        next_waddr = cmd_addr;
        next_len = cmd_len;
        next_nack = 1'b0;
        next_step = (cmd_kind == SE_KIND_CUR) ? 2'd2 : 2'd0;
        next_scl = 1'b0;
        next_st = SE_H_START;
      end
    end else if (tick) begin
      next_q = nq;
      case (nq)
        2'd1: next_scl = 1'b1;
        2'd2: begin
          if (st == SE_H_START) begin
            next_oe = 1'b1;
          end else if (st == SE_H_STOP) begin
            next_oe = 1'b0;
          end else if (st == SE_H_TX && bitn == `SE_ACK_BIT) begin
            next_ackbit = sda_s2;
          end else if (st == SE_H_RX && bitn < `SE_ACK_BIT) begin
            next_sh = {sh[6:0], sda_s2};
          end
        end
        2'd3: begin
          if (st == SE_H_STOP) begin
            next_st = SE_H_IDLE;
            next_done = 1'b1;
          end else begin
            next_scl = 1'b0;
          end
        end
        default: begin
          case (st)
            SE_H_START: begin
              next_st = SE_H_TX;
              next_bitn = 4'd0;
              next_sh = (step == 2'd2) ? devr : devw;
              next_oe = (step == 2'd2) ? ~devr[7] : ~devw[7];
            end
            SE_H_TX: begin
              if (bitn < `SE_ACK_BIT) begin
                next_bitn = bitn + 4'd1;
                next_sh = {sh[6:0], 1'b0};
                next_oe = (bitn == `SE_LAST_BIT) ? 1'b0 : ~sh[6];
              end else if (ackbit) begin
                if (kind == SE_KIND_POLL) begin
                  next_st = SE_H_START;
                  next_oe = 1'b0;
                end else begin
                  next_nack = 1'b1;
                  next_st = SE_H_STOP;
                  next_oe = 1'b1;
                end
              end else if (step == 2'd0 && kind == SE_KIND_POLL) begin
                next_st = SE_H_STOP;
                next_oe = 1'b1;
              end else if (step == 2'd0) begin
                next_step = 2'd1;
                next_bitn = 4'd0;
                next_sh = waddr;
                next_oe = ~waddr[7];
              end else if (step == 2'd1) begin
                next_step = 2'd2;
                next_st = SE_H_START;
                next_oe = 1'b0;
              end else begin
                next_step = 2'd3;
                next_st = SE_H_RX;
                next_bitn = 4'd0;
                next_oe = 1'b0;
              end
            end
            SE_H_RX: begin
              if (bitn < `SE_ACK_BIT) begin
                next_bitn = bitn + 4'd1;
                if (bitn == `SE_LAST_BIT) begin
                  next_rd_valid = 1'b1;
                  next_rd_data = sh;
                  next_oe = (len != 8'h00);
                end
              end else if (len != 8'h00) begin
                next_len = len - 8'h01;
                next_bitn = 4'd0;
                next_oe = 1'b0;
              end else begin
                next_st = SE_H_STOP;
                next_oe = 1'b1;
              end
            end
            default: next_st = SE_H_IDLE;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= SE_H_IDLE;
      kind <= SE_KIND_CUR;
      qc <= 16'h0000;
      q <= 2'd0;
      step <= 2'd0;
      bitn <= 4'd0;
      sh <= 8'h00;
      len <= 8'h00;
      strap <= 3'h0;
      waddr <= '0;
      ackbit <= 1'b1;
      scl <= 1'b1;
      oe <= 1'b0;
      cmd_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      qc <= next_qc;
      q <= next_q;
      step <= next_step;
      bitn <= next_bitn;
      sh <= next_sh;
      len <= next_len;
      strap <= next_strap;
      waddr <= next_waddr;
      ackbit <= next_ackbit;
      scl <= next_scl;
      oe <= next_oe;
      cmd_ready <= (next_st == SE_H_IDLE) && !(cmd_valid && cmd_ready);
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      done <= next_done;
      nack <= next_nack;
    end
  end

  assign link.scl = scl;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = oe;

endmodule

`default_nettype wire

//--- se_link_assertions.sv
// Checker for the two-wire link between the bus master and the memory slave
`timescale 1ns/10ps
`default_nettype none
`include "se_map.svh"

module se_link_assertions (
  input wire logic clock,           // Master clock
  input wire logic reset_n,         // Async reset, active low
  input wire logic scl,             // Link clock
  input wire logic host_sda_oe,     // Master pulls data low
  input wire logic dev_sda_oe,      // Slave pulls data low
  input wire logic sda,             // Resolved data line
  input wire logic write_busy,      // Slave write running
  input wire logic chip_strap_bit0, // Strap 0
  input wire logic chip_strap_bit1, // Strap 1
  input wire logic chip_strap_bit2  // Strap 2
);
  // ==========================================================
  // Frame tracking
  logic scl_q, sda_q, in_frame, rd_dir, acked0, busy_seen;
  logic [3:0] pos;
  logic [7:0] nbyte, sh;
  logic hi, slot0, match;
  assign hi = scl && scl_q;
  assign slot0 = hi && pos == 4'h9 && nbyte == 8'h00;
  assign match = sh[7:4] == `SE_DEV_TYPE &&
                 sh[3:1] == {chip_strap_bit2, chip_strap_bit1, chip_strap_bit0};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      rd_dir <= 1'b0;
      acked0 <= 1'b0;
      busy_seen <= 1'b0;
      pos <= 4'h0;
      nbyte <= 8'h00;
      sh <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      busy_seen <= busy_seen | write_busy;
      if (hi && sda_q != sda) begin
        // Start or stop restarts the bit count
        in_frame <= !sda;
        busy_seen <= write_busy;
        pos <= 4'h0;
        nbyte <= 8'h00;
      end else if (scl && !scl_q) begin
        pos <= (pos == 4'h9) ? 4'h1 : pos + 4'h1;
        nbyte <= nbyte + {7'h00, pos == 4'h9};
        if (pos != 4'h8) begin
          sh <= {sh[6:0], sda};
        end
      end
      if (slot0) begin
        rd_dir <= sh[0];
        acked0 <= !sda;
      end
    end
  end

  // ==========================================================
  // Link properties
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_busy_no_ack: assert property (slot0 && write_busy |-> !dev_sda_oe)
    else $error("address acked while write busy");
  a_bad_addr_nack: assert property (slot0 && !match |-> !dev_sda_oe)
    else $error("address acked on mismatch");
  a_good_addr_ack: assert property (slot0 && match && !busy_seen |-> dev_sda_oe && !sda)
    else $error("matching address not acked");
  a_hold_scl_high: assert property (hi |-> $stable(dev_sda_oe))
    else $error("slave changed data while clock high");
  a_standby_quiet: assert property (!in_frame |-> !dev_sda_oe)
    else $error("slave drives outside a frame");
  a_write_no_drive: assert property (
    hi && !rd_dir && nbyte != 8'h00 && pos != 4'h9 |-> !dev_sda_oe)
    else $error("slave drives data in write direction");
  a_word_addr_ack: assert property (
    hi && !rd_dir && acked0 && nbyte == 8'h01 && pos == 4'h9 |-> dev_sda_oe)
    else $error("word address not acked");
  a_master_quiet_rd: assert property (
    hi && rd_dir && nbyte != 8'h00 && pos > 4'h1 && pos < 4'h9 |-> !host_sda_oe)
    else $error("master drives during read data");
endmodule

`default_nettype wire

//--- se_link_if.sv
// Two-wire link between the bus master and the memory slave
`timescale 1ns/10ps
`default_nettype none

interface se_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // Open drain with pull-up: low whenever either end drives a zero
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport host (
    output scl,
    output host_sda_out,
    output host_sda_oe,
    input sda
  );

  modport dev (
    input scl,
    output dev_sda_out,
    output dev_sda_oe,
    input sda
  );
endinterface

`default_nettype wire

//--- se_map.svh
// Constants shared by the serial memory slave and its bus master
`ifndef SE_MAP_SVH
`define SE_MAP_SVH

// ==========================================================
// Address word framing
`define SE_DEV_TYPE 4'ha
`define SE_RW_READ 1'b1
`define SE_LAST_BIT 4'd7
`define SE_ACK_BIT 4'd8

// ==========================================================
// Array geometry
`define SE_MEM_BYTES 256
`define SE_ADDR_W 8

// ==========================================================
// Timing
`define SE_CLK_PERIOD_NS 8
`define SE_SCL_PERIOD_NS 2000
`define SE_QTR_CYC (`SE_SCL_PERIOD_NS / (4 * `SE_CLK_PERIOD_NS))

`endif

//--- se_pkg.sv
// Types shared by the serial memory slave and its bus master
`default_nettype none

package se_pkg;

  typedef enum logic [1:0] {
    SE_KIND_CUR,
    SE_KIND_RAND,
    SE_KIND_POLL
  } se_kind_e;

  typedef enum logic [2:0] {
    SE_D_IDLE,
    SE_D_DEVADR,
    SE_D_ACK_DEV,
    SE_D_WADDR,
    SE_D_ACK_WA,
    SE_D_RDATA,
    SE_D_RACK,
    SE_D_HOLD
  } se_dstate_e;

  typedef enum logic [2:0] {
    SE_H_IDLE,
    SE_H_START,
    SE_H_TX,
    SE_H_RX,
    SE_H_STOP
  } se_hstate_e;

endpackage

`default_nettype wire

//--- serial_eeprom_read_and_ack_poll_tb.sv
// Bench for the memory slave and its bus master joined over the link
`timescale 1ns/10ps
`default_nettype none

module serial_eeprom_read_and_ack_poll_tb;
  import se_pkg::*;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic write_busy = 1'b0;
  logic [2:0] strap = 3'h0;
  logic fill_valid = 1'b0;
  logic [7:0] fill_addr = 8'h00;
  logic [7:0] fill_data = 8'h00;
  logic fill_ready;
  logic cmd_valid = 1'b0;
  se_kind_e cmd_kind = SE_KIND_CUR;
  logic [2:0] cmd_strap = 3'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic cmd_ready, rd_valid, done, nack;
  logic [7:0] rd_data;
  logic [7:0] mem [256];
  int ctr = 0;
  int n_fail = 0;
  int n_checks = 0;
  int i;

  initial forever #4 clock = ~clock;
  // Link clock phase unrelated to the master clock
  initial begin
    #3.1;
    forever #6 link_clk = ~link_clk;
  end

  se_link_if link ();
  se_dev se_dev_i (.clock(clock), .reset_n(reset_n), .link_clk(link_clk),
    .write_busy(write_busy), .chip_strap_bit0(strap[0]), .chip_strap_bit1(strap[1]),
    .chip_strap_bit2(strap[2]), .fill_valid(fill_valid), .fill_addr(fill_addr),
    .fill_data(fill_data), .fill_ready(fill_ready), .link(link));
  // Short bit time keeps the run brief; still above the slave's sampling latency
  se_host #(.QTR(8)) se_host_i (.clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_strap(cmd_strap), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .nack(nack), .link(link));
  se_link_assertions se_link_assertions_i (.clock(clock), .reset_n(reset_n),
    .scl(link.scl), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
    .sda(link.sda), .write_busy(write_busy), .chip_strap_bit0(strap[0]),
    .chip_strap_bit1(strap[1]), .chip_strap_bit2(strap[2]));

  // ==========================================================
  // Reporting
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up;
    n_fail++;
    $display("mismatch at %0t: got %h expected %h (wait expired)", $time, 1'b0, 1'b1);
    report_and_stop();
  endtask

  // ==========================================================
  // Drivers
  task automatic fill(input logic [7:0] a, input logic [7:0] d);
    int k;
    for (k = 0; k < 100 && fill_ready !== 1'b1; k++) @(negedge clock);
    if (k == 100) give_up();
    fill_valid = 1'b1;
    fill_addr = a;
    fill_data = d;
    @(negedge clock);
    fill_valid = 1'b0;
  endtask

  task automatic run_cmd(input se_kind_e kind, input logic [2:0] s, input logic [7:0] a,
                         input logic [7:0] len, input logic exp_nack);
    int k;
    int got;
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge clock);
    if (k == 100) give_up();
    cmd_valid = 1'b1;
    cmd_kind = kind;
    cmd_strap = s;
    cmd_addr = a;
    cmd_len = len;
    @(negedge clock);
    cmd_valid = 1'b0;
    if (kind == SE_KIND_RAND && !exp_nack) ctr = a;
    got = 0;
    for (k = 0; k < 20000 && done !== 1'b1; k++) begin
      @(negedge clock);
      if (rd_valid === 1'b1) begin
        check(rd_data, mem[ctr]);
        ctr = (ctr + 1) % 256;
        got++;
      end
    end
    if (k == 20000) give_up();
    check({7'h00, nack}, {7'h00, exp_nack});
    check(8'(got), (exp_nack || kind == SE_KIND_POLL) ? 8'h00 : len + 8'h01);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'ha617));
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    strap = 3'($urandom);
    for (i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      fill(8'(i), mem[i]);
    end
    run_cmd(SE_KIND_CUR, strap, 8'h00, 8'h00, 1'b0);
    run_cmd(SE_KIND_RAND, strap, 8'hfd, 8'h05, 1'b0);
    run_cmd(SE_KIND_CUR, strap, 8'h00, 8'h02, 1'b0);
    run_cmd(SE_KIND_CUR, ~strap, 8'h00, 8'h00, 1'b1);
    write_busy = 1'b1;
    repeat (20) @(negedge clock);
    run_cmd(SE_KIND_RAND, strap, 8'h40, 8'h00, 1'b1);
    fork
      run_cmd(SE_KIND_POLL, strap, 8'h00, 8'h00, 1'b0);
      begin
        repeat (2000) @(negedge clock);
        write_busy = 1'b0;
      end
    join
    run_cmd(SE_KIND_CUR, strap, 8'h00, 8'h01, 1'b0);
    for (i = 0; i < 6; i++) begin
      strap = 3'($urandom);
      repeat (20) @(negedge clock);
      run_cmd(($urandom % 2) ? SE_KIND_RAND : SE_KIND_CUR, strap, 8'($urandom),
              8'($urandom % 4), 1'b0);
    end
    // Power loss model: reset clears the counter, the array keeps its bytes
    reset_n = 1'b0;
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    ctr = 0;
    run_cmd(SE_KIND_CUR, strap, 8'h00, 8'h01, 1'b0);
    report_and_stop();
  end
endmodule

`default_nettype wire
